// [inc/dpt_pkg.sv]
// ============================================================
// Dual PWM timer: shared constants and helpers
// ============================================================
package dpt_pkg;

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned PRE_W   = 3;
   localparam int unsigned DIV_W   = 8;
   localparam int unsigned IDX_W   = 4;

   // ==========================================================
   // Register indices (byte address = index * 4)
   // ==========================================================
   localparam logic [IDX_W-1:0] IDX_FIRST_COUNTER  = 4'h0;
   localparam logic [IDX_W-1:0] IDX_SECOND_COUNTER = 4'h1;
   localparam logic [IDX_W-1:0] IDX_FIRST_PERIOD   = 4'h2;
   localparam logic [IDX_W-1:0] IDX_SECOND_PERIOD  = 4'h3;
   localparam logic [IDX_W-1:0] IDX_FIRST_DUTY     = 4'h4;
   localparam logic [IDX_W-1:0] IDX_SECOND_DUTY    = 4'h5;
   localparam logic [IDX_W-1:0] IDX_MATCH_FLAGS    = 4'h6;
   localparam logic [IDX_W-1:0] IDX_PWM_CONTROL    = 4'h7;
   localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL  = 4'h8;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int unsigned WAVE1_EN_BIT    = 0;
   localparam int unsigned WAVE2_EN_BIT    = 1;
   localparam int unsigned CASCADE_BIT     = 2;
   localparam int unsigned PRE1_LSB        = 0;
   localparam int unsigned PRE2_LSB        = 3;
   localparam int unsigned COUNT1_EN_BIT   = 6;
   localparam int unsigned COUNT2_EN_BIT   = 7;
   localparam int unsigned PWM_CHANNEL_CONTROL_USED_W   = 3;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [PWM_CHANNEL_CONTROL_USED_W-1:0] PWM_CONTROL_RST   = 3'h0;
   localparam logic [DATA_W-1:0]        TIMER_CONTROL_RST = 8'h00;
   localparam logic [DATA_W-1:0]        BYTE_RST          = 8'h00;

   // Prescale ratio for a 3-bit select code; note 1:32 is skipped
   function automatic logic [DIV_W:0] dpt_ratio(input logic [PRE_W-1:0] sel);
      case (sel)
         3'h0:    dpt_ratio = 9'h001;
         3'h1:    dpt_ratio = 9'h002;
         3'h2:    dpt_ratio = 9'h004;
         3'h3:    dpt_ratio = 9'h008;
         3'h4:    dpt_ratio = 9'h010;
         3'h5:    dpt_ratio = 9'h040;
         3'h6:    dpt_ratio = 9'h080;
         default: dpt_ratio = 9'h100;
      endcase
   endfunction : dpt_ratio

endpackage : dpt_pkg

// [rtl/dpt_prescaler.sv]
`timescale 1ns/1ns
// ============================================================
// Programmable prescaler: one tick every ratio input cycles
// ============================================================
module dpt_prescaler (
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   input  wire logic                       run,
   input  wire logic [dpt_pkg::PRE_W-1:0]  sel,
   output logic                            tick
);
   import dpt_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] div;
   } dpt_pre_state_t;

   dpt_pre_state_t s_q;
   dpt_pre_state_t s_d;
   logic [DIV_W:0] last;

   always_comb begin
      last = dpt_ratio(sel) - 9'h001;
      tick = run && ({1'b0, s_q.div} >= last);
      s_d  = s_q;
      // A stopped timer keeps its partial count
      if (run) begin
         if (tick) begin
            s_d.div = '0;
         end else begin
            s_d.div = s_q.div + 8'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : dpt_prescaler

// [rtl/dpt_timer.sv]
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
module dpt_timer (
   input  wire logic                        clock,
   input  wire logic                        arst_n,
   // AHB-Lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic [31:0]                      hrdata,
   // System state
   input  wire logic                        sleep_mode,
   input  wire logic                        conversion_busy,
   // Wave pins and flags
   output logic                             first_wave_out,
   output logic                             second_wave_out,
   output logic                             first_match_flag,
   output logic                             second_match_flag
);
   import dpt_pkg::*;

   localparam int unsigned NCH = 2;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic                       wr_pend;
      logic [IDX_W-1:0]           wr_idx;
      logic [31:0]                rdata;
      logic [PWM_CHANNEL_CONTROL_USED_W-1:0]   pwm_control;
      logic [DATA_W-1:0]          timer_control;
      logic [NCH-1:0][DATA_W-1:0] period;
      logic [NCH-1:0][DATA_W-1:0] duty;
      logic [NCH-1:0][DATA_W-1:0] latch;
      logic [NCH-1:0][DATA_W-1:0] count;
      logic [NCH-1:0]             wave;
      logic [NCH-1:0]             flag;
      logic                       sleep_seen;
      logic                       sleep_halt;
   } dpt_state_t;

   dpt_state_t s_q;
   dpt_state_t s_d;

   logic [NCH-1:0]             tick;
   logic [NCH-1:0]             run;
   logic [NCH-1:0][PRE_W-1:0]  pre_sel;
   logic [NCH-1:0]             wave_en;
   logic [NCH-1:0]             match_set;
   logic                       cascade;
   logic                       addr_ok;
   logic                       take;
   logic [IDX_W-1:0]           a_idx;
   logic [2*DATA_W-1:0]        c16;
   logic [2*DATA_W-1:0]        n16;
   logic [DATA_W-1:0]          n8;

   // Read view of a register index; unmapped indices read zero
   function automatic logic [31:0] read_reg(input dpt_state_t s, input logic [IDX_W-1:0] idx);
      read_reg = '0;
      case (idx)
         IDX_FIRST_COUNTER:  read_reg[DATA_W-1:0] = s.count[0];
         IDX_SECOND_COUNTER: read_reg[DATA_W-1:0] = s.count[1];
         IDX_FIRST_PERIOD:   read_reg[DATA_W-1:0] = s.period[0];
         IDX_SECOND_PERIOD:  read_reg[DATA_W-1:0] = s.period[1];
         IDX_FIRST_DUTY:     read_reg[DATA_W-1:0] = s.duty[0];
         IDX_SECOND_DUTY:    read_reg[DATA_W-1:0] = s.duty[1];
         IDX_MATCH_FLAGS:    read_reg[NCH-1:0]    = s.flag;
         IDX_PWM_CONTROL:    read_reg[PWM_CHANNEL_CONTROL_USED_W-1:0] = s.pwm_control;
         IDX_TIMER_CONTROL:  read_reg[DATA_W-1:0] = s.timer_control;
         default:            read_reg = '0;
      endcase
   endfunction : read_reg

   // ==========================================================
   // Control decode
   // ==========================================================
   always_comb begin
      cascade    = s_q.pwm_control[CASCADE_BIT];
      wave_en[0] = s_q.pwm_control[WAVE1_EN_BIT];
      wave_en[1] = s_q.pwm_control[WAVE2_EN_BIT];
      pre_sel[0] = s_q.timer_control[PRE1_LSB +: PRE_W];
      pre_sel[1] = s_q.timer_control[PRE2_LSB +: PRE_W];
      // Second prescaler idles in cascade: the pair steps on the first one
      run[0]     = s_q.timer_control[COUNT1_EN_BIT] && !s_q.sleep_halt;
      run[1]     = s_q.timer_control[COUNT2_EN_BIT] && !s_q.sleep_halt && !cascade;
   end

   // ==========================================================
   // Prescalers
   // ==========================================================
   dpt_prescaler u_pre0 (
      .clock  (clock),
      .arst_n (arst_n),
      .run    (run[0]),
      .sel    (pre_sel[0]),
      .tick   (tick[0])
   );

   dpt_prescaler u_pre1 (
      .clock  (clock),
      .arst_n (arst_n),
      .run    (run[1]),
      .sel    (pre_sel[1]),
      .tick   (tick[1])
   );

   // ==========================================================
   // Bus address phase
   // ==========================================================
   always_comb begin
      addr_ok = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'b00);
      take    = hsel && htrans[1] && hready;
      a_idx   = haddr[5:2];
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      s_d       = s_q;
      match_set = '0;
      c16       = {s_q.count[1], s_q.count[0]};
      n16       = c16 + 16'h0001;
      n8        = '0;

      // Sleep entry decides, once, whether the counters halt
      s_d.sleep_seen = sleep_mode;
      if (!sleep_mode) begin
         s_d.sleep_halt = 1'b0;
      end else if (!s_q.sleep_seen) begin
         s_d.sleep_halt = !conversion_busy;
      end

      // Counting; a stopped channel keeps everything
      if (cascade) begin
         if (tick[0]) begin
            if (c16 == {s_q.period[1], s_q.period[0]}) begin
               s_d.count[0] = '0;
               s_d.count[1] = '0;
               s_d.latch[0] = s_q.duty[0];
               s_d.latch[1] = s_q.duty[1];
               s_d.wave[0]  = ({s_q.duty[1], s_q.duty[0]} != 16'h0000);
               match_set[0] = 1'b1;
            end else begin
               s_d.count[0] = n16[DATA_W-1:0];
               s_d.count[1] = n16[2*DATA_W-1:DATA_W];
               if (n16 == {s_q.latch[1], s_q.latch[0]}) begin
                  s_d.wave[0] = 1'b0;
               end
            end
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            n8 = s_q.count[i] + 8'h01;
            if (tick[i]) begin
               if (s_q.count[i] == s_q.period[i]) begin
                  s_d.count[i] = '0;
                  s_d.latch[i] = s_q.duty[i];
                  s_d.wave[i]  = (s_q.duty[i] != 8'h00);
                  match_set[i] = 1'b1;
               end else begin
                  s_d.count[i] = n8;
                  if (n8 == s_q.latch[i]) begin
                     s_d.wave[i] = 1'b0;
                  end
               end
            end
         end
      end

      // A disabled wave function leaves the pin low
      for (int i = 0; i < NCH; i++) begin
         if (!wave_en[i]) begin
            s_d.wave[i] = 1'b0;
         end
      end
      if (cascade) begin
         s_d.wave[1] = s_q.wave[1] && wave_en[1];
      end

      // Data phase of a write
      s_d.wr_pend = 1'b0;
      if (s_q.wr_pend) begin
         case (s_q.wr_idx)
            IDX_FIRST_PERIOD:  s_d.period[0] = hwdata[DATA_W-1:0];
            IDX_SECOND_PERIOD: s_d.period[1] = hwdata[DATA_W-1:0];
            IDX_FIRST_DUTY:    s_d.duty[0]   = hwdata[DATA_W-1:0];
            IDX_SECOND_DUTY:   s_d.duty[1]   = hwdata[DATA_W-1:0];
            IDX_MATCH_FLAGS:   s_d.flag      = s_q.flag & hwdata[NCH-1:0];
            IDX_PWM_CONTROL:   s_d.pwm_control = hwdata[PWM_CHANNEL_CONTROL_USED_W-1:0];
            IDX_TIMER_CONTROL: s_d.timer_control = hwdata[DATA_W-1:0];
            default:           s_d.flag      = s_d.flag;
         endcase
      end

      // A match in the clearing cycle wins over the clear
      s_d.flag = s_d.flag | match_set;

      // Address phase: capture write target, fetch read data
      if (take && hwrite && addr_ok) begin
         s_d.wr_pend = 1'b1;
         s_d.wr_idx  = a_idx;
      end
      if (take && !hwrite) begin
         // Read the post-edge view so a read right after a write sees it
         s_d.rdata = addr_ok ? read_reg(s_d, a_idx) : 32'h0;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q               <= '0;
         s_q.pwm_control   <= PWM_CONTROL_RST;
         s_q.timer_control <= TIMER_CONTROL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign first_wave_out    = s_q.wave[0];
   assign second_wave_out   = s_q.wave[1];
   assign first_match_flag  = s_q.flag[0];
   assign second_match_flag = s_q.flag[1];

endmodule : dpt_timer

// [verification/dpt_timer_sva.sv]
`timescale 1ns/1ns
// ========================================
// Port-level checks of the dual wave timer
// ========================================
module dpt_timer_sva (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        sleep_mode,
   input wire logic        conversion_busy,
   input wire logic        first_wave_out,
   input wire logic        second_wave_out,
   input wire logic        first_match_flag,
   input wire logic        second_match_flag
);
   logic        rd_q, wr_q, slp_q, halt_q;
   logic [1:0]  clr_q;
   logic [31:0] adr_q;
   wire  logic  take = hsel && htrans[1] && hready;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rd_q   <= 1'b0;
         wr_q   <= 1'b0;
         slp_q  <= 1'b0;
         halt_q <= 1'b0;
         clr_q  <= 2'h0;
         adr_q  <= 32'h0;
      end else begin
         rd_q   <= take && !hwrite;
         wr_q   <= take && hwrite;
         adr_q  <= take ? haddr : adr_q;
         clr_q  <= (wr_q && adr_q == 32'h18) ? ~hwdata[1:0] : 2'h0;
         slp_q  <= sleep_mode;
         // Halting is decided once, at the moment sleep begins
         halt_q <= sleep_mode && (halt_q || (!slp_q && !conversion_busy));
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   a_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_reset_outputs_low: assert property (
      $rose(arst_n) |-> !first_wave_out && !second_wave_out && !first_match_flag)
      else $error("output not low after reset");
   a_rise_sets_first: assert property (
      $rose(first_wave_out) |-> first_match_flag) else $error("first rise without flag");
   a_rise_sets_second: assert property (
      $rose(second_wave_out) |-> second_match_flag) else $error("second rise without flag");
   a_first_flag_clear: assert property (
      $fell(first_match_flag) |-> clr_q[0]) else $error("first flag fell without clear");
   a_second_flag_clear: assert property (
      $fell(second_match_flag) |-> clr_q[1]) else $error("second flag fell without clear");
   a_unmapped_reads_zero: assert property (rd_q && adr_q[31:6] != 26'h0 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_read_upper_zero: assert property (rd_q |-> hrdata[31:8] == 24'h0)
      else $error("read upper bits not zero");
   a_sleep_holds_waves: assert property (
      halt_q && $past(halt_q) |-> $stable(first_wave_out) && $stable(second_wave_out))
      else $error("wave moved while halted");

   c_first_rise: cover property ($rose(first_wave_out));
   c_second_rise: cover property ($rose(second_wave_out));
   c_flag_clear: cover property ($fell(first_match_flag));
   c_halted: cover property (halt_q && $past(halt_q));
endmodule : dpt_timer_sva

bind dpt_timer dpt_timer_sva u_sva (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hresp, .hrdata, .sleep_mode, .conversion_busy,
   .first_wave_out, .second_wave_out, .first_match_flag, .second_match_flag);

// [verification/test_dual_pwm_timer.sv]
`timescale 1ns/1ns
module test_dual_pwm_timer;
   import dpt_pkg::*;
   logic              clock, arst_n, hsel, hwrite, sleep_mode, conversion_busy, ch;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       haddr, hwdata, r, t, rnd;
   wire  logic        hready, hreadyout, hresp, first_wave_out, second_wave_out;
   wire  logic        first_match_flag, second_match_flag;
   wire  logic [31:0] hrdata;
   wire  logic [1:0]  pins = {second_wave_out, first_wave_out};
   int                bad_count, n_tests, hi, per, p, d, k;

   assign hready = hreadyout;
   dpt_timer DUT (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_mode(sleep_mode),
      .conversion_busy(conversion_busy), .first_wave_out(first_wave_out),
      .second_wave_out(second_wave_out), .first_match_flag(first_match_flag),
      .second_match_flag(second_match_flag));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ==========================================
   // Helpers
   // ==========================================
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Code 5 skips a ratio, so the upper codes shift one further
   function automatic int ratio(input int c);
      return (c < 5) ? (1 << c) : (1 << (c + 1));
   endfunction : ratio
   function automatic logic [31:0] ba(input logic [3:0] i);
      return {26'h0, i, 2'h0};
   endfunction : ba

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dat);
      @(posedge clock);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= dat;
      do @(posedge clock); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [7:0] v);
      rnd = lfsr(rnd);
      bus(1'b1, a, {rnd[31:8], v});
   endtask : wr
   task automatic rd(input logic [31:0] a);
      rnd = lfsr(rnd);
      bus(1'b0, a, rnd);
   endtask : rd
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   // Counts one whole period from a rising edge of the chosen pin
   task automatic measure(input logic c);
      do @(posedge clock); while (pins[c] !== 1'b0);
      do @(posedge clock); while (pins[c] !== 1'b1);
      hi = 1; per = 1; k = 0;
      forever begin
         @(posedge clock);
         if (pins[c] === 1'b1 && k != 0) break;
         per++;
         if (pins[c] === 1'b1) hi++; else k = 1;
      end
   endtask : measure
   task automatic give_verdict;
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (90000) @(posedge clock);
      bad_count++;
      give_verdict();
   end

   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      {hsel, hwrite, sleep_mode, conversion_busy, htrans, hsize} = '0;
      haddr = 32'h0; hwdata = 32'h0; rnd = 32'hf30c; arst_n = 1'b0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      rd(ba(IDX_TIMER_CONTROL)); check("timer_ctl", 32'h0, r);
      rd(ba(IDX_MATCH_FLAGS)); check("flags", 32'h0, r);
      wr(32'h40, 8'h5a); rd(32'h40); check("unmapped", 32'h0, r);
      wr(ba(IDX_PWM_CONTROL), 8'hff); rd(ba(IDX_PWM_CONTROL)); check("pwm_ctl", 32'h7, r);
      wr(ba(IDX_FIRST_COUNTER), 8'h33); rd(ba(IDX_FIRST_COUNTER)); check("cnt_ro", 32'h0, r);
      // Cascade while both counters still sit at zero
      wr(ba(IDX_FIRST_PERIOD), 8'h03); wr(ba(IDX_SECOND_PERIOD), 8'h01);
      wr(ba(IDX_FIRST_DUTY), 8'h80); wr(ba(IDX_SECOND_DUTY), 8'h00);
      wr(ba(IDX_PWM_CONTROL), 8'h05); wr(ba(IDX_TIMER_CONTROL), 8'h40);
      measure(1'b0); check("cas_hi", 32'h80, 32'(hi)); check("cas_per", 32'h104, 32'(per));
      rd(ba(IDX_MATCH_FLAGS)); check("cas_flags", 32'h1, r);
      wr(ba(IDX_TIMER_CONTROL), 8'h00); wr(ba(IDX_PWM_CONTROL), 8'h00);
      // Periods grow so a counter held from an earlier pass never starts above its new period
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd); ch = i[0];
         p = 4 + 2 * i + int'(rnd[0]); d = 1 + int'(rnd[15:8]) % p;
         wr(ba(ch ? IDX_SECOND_PERIOD : IDX_FIRST_PERIOD), p[7:0]);
         wr(ba(ch ? IDX_SECOND_DUTY : IDX_FIRST_DUTY), d[7:0]);
         wr(ba(IDX_PWM_CONTROL), ch ? 8'h02 : 8'h01);
         wr(ba(IDX_TIMER_CONTROL), ch ? (8'h80 | 8'(i << 3)) : (8'h40 | 8'(i)));
         measure(ch);
         check("hi", 32'(d * ratio(i)), 32'(hi));
         check("per", 32'(p * ratio(i) + ratio(i)), 32'(per));
         wr(ba(IDX_TIMER_CONTROL), 8'h00);
      end
      // Duty written during high time waits for the next boundary
      wr(ba(IDX_FIRST_PERIOD), 8'h27); wr(ba(IDX_FIRST_DUTY), 8'h14);
      wr(ba(IDX_PWM_CONTROL), 8'h01); wr(ba(IDX_TIMER_CONTROL), 8'h40);
      measure(1'b0); check("hi_a", 32'h14, 32'(hi));
      wr(ba(IDX_FIRST_DUTY), 8'h1e);
      k = 0;
      while (pins[0] === 1'b1) begin k++; @(posedge clock); end
      check("hi_kept", 32'h11, 32'(k));
      measure(1'b0); check("hi_b", 32'h1e, 32'(hi)); check("per_b", 32'h28, 32'(per));
      wr(ba(IDX_FIRST_DUTY), 8'h00);
      repeat (80) @(posedge clock);
      k = 0;
      repeat (120) begin @(posedge clock); if (pins[0] !== 1'b0) k++; end
      check("zero_duty", 32'h0, 32'(k));
      wr(ba(IDX_FIRST_DUTY), 8'h14);
      // Disabled counter holds, then flags are cleared one at a time
      wr(ba(IDX_TIMER_CONTROL), 8'h00); rd(ba(IDX_FIRST_COUNTER)); t = r;
      repeat (50) @(posedge clock);
      rd(ba(IDX_FIRST_COUNTER)); check("held", t, r);
      wr(ba(IDX_MATCH_FLAGS), 8'h02); rd(ba(IDX_MATCH_FLAGS)); check("flag_keep", 32'h2, r);
      wr(ba(IDX_MATCH_FLAGS), 8'h00); rd(ba(IDX_MATCH_FLAGS)); check("flag_clr", 32'h0, r);
      // Sleep halts unless a conversion is running when it begins
      wr(ba(IDX_TIMER_CONTROL), 8'h40);
      sleep_mode <= 1'b1;
      repeat (5) @(posedge clock);
      rd(ba(IDX_FIRST_COUNTER)); t = r;
      repeat (60) @(posedge clock);
      rd(ba(IDX_FIRST_COUNTER)); check("sleep_halt", t, r);
      sleep_mode <= 1'b0;
      @(posedge clock);
      conversion_busy <= 1'b1; sleep_mode <= 1'b1;
      repeat (5) @(posedge clock);
      rd(ba(IDX_FIRST_COUNTER)); t = r;
      repeat (20) @(posedge clock);
      rd(ba(IDX_FIRST_COUNTER)); check("sleep_run", 32'h1, {31'h0, r !== t});
      give_verdict();
   end
endmodule : test_dual_pwm_timer
